/* File: design/eicp_pkg.sv */
// Package with the command encodings, field positions and timing of the command port.
package eicp_pkg;

   // Command word layout: operation code on top, frame address below it.
   localparam int CMD_W = 40;
   localparam int OP_W = 4;
   localparam int OP_LSB = 36;
   localparam int ADDR_W = 36;

   // Operation codes carried in the top nibble of the command word.
   localparam logic [3:0] OP_GO_IDLE = 4'he;
   localparam logic [3:0] OP_GO_OBSERVE = 4'ha;
   localparam logic [3:0] OP_SOFT_RESET = 4'hb;
   localparam logic [3:0] OP_INJECT_PHYS = 4'hc;
   localparam logic [3:0] OP_INJECT_LIN = 4'hd;

   // Length of the initialization sequence, in clock cycles.
   localparam logic [3:0] INIT_CYCLES = 4'h8;
   localparam logic [3:0] CNT_RESET = 4'h0;

   // Supported and masked address windows after reset.
   localparam logic [35:0] PHYS_ADDR_MAX = 36'h0_0fff_ffff;
   localparam logic [35:0] LIN_ADDR_MAX = 36'h0_000f_ffff;
   localparam logic [35:0] MASK_LO = 36'h0_0000_0000;
   localparam logic [35:0] MASK_HI = 36'h0_0000_0000;
   localparam logic MASK_EN = 1'h0;

   // Controller states.
   typedef enum logic [2:0] {
      ST_BOOT,
      ST_INIT,
      ST_OBSERVE,
      ST_IDLE,
      ST_INJECT
   } eicp_state_type;

endpackage

/* File: design/eicp_port.sv */
// Error injection command port with one command decoder per stacked die region.
`timescale 1ns/1ps
module eicp_port #(
   parameter int NUM_REGIONS = 1,
   parameter bit PORT_EN = 1'b1,
   parameter logic [35:0] PHYS_MAX = eicp_pkg::PHYS_ADDR_MAX,
   parameter logic [35:0] LIN_MAX = eicp_pkg::LIN_ADDR_MAX
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Command port
   input wire logic [eicp_pkg::CMD_W-1:0] cmd_word,
   input wire logic cmd_strobe,
   // Per region status
   output logic [NUM_REGIONS-1:0] status_initialization,
   output logic [NUM_REGIONS-1:0] status_observation,
   output logic [NUM_REGIONS-1:0] status_idle,
   output logic [NUM_REGIONS-1:0] status_injection,
   // Per region injection request
   output logic [NUM_REGIONS-1:0] inject_fire,
   output logic [NUM_REGIONS-1:0] inject_linear,
   output logic [NUM_REGIONS-1:0] inject_dropped,
   output logic [NUM_REGIONS*eicp_pkg::ADDR_W-1:0] inject_addr
);

   typedef struct packed {
      eicp_pkg::eicp_state_type state;
      logic [eicp_pkg::CMD_W-1:0] cmd;
      logic pend;
      logic [3:0] cnt;
      logic [eicp_pkg::ADDR_W-1:0] addr;
      logic linear;
      logic fire;
      logic dropped;
   } eicp_regs_type;

   // With the port disabled the inputs are cut off here, so the decoders never see a command.
   logic strobe_in;
   logic [eicp_pkg::CMD_W-1:0] word_in;
   assign strobe_in = PORT_EN ? cmd_strobe : 1'b0;
   assign word_in = PORT_EN ? cmd_word : '0;

   genvar g;
   generate
      for (g = 0; g < NUM_REGIONS; g++) begin : g_region
         eicp_regs_type r_q;
         eicp_regs_type r_d;
         logic [3:0] op;
         logic [eicp_pkg::ADDR_W-1:0] adr;
         logic is_inject;
         logic in_range;
         logic masked;

         assign op = r_q.cmd[eicp_pkg::OP_LSB +: eicp_pkg::OP_W];
         assign adr = r_q.cmd[eicp_pkg::ADDR_W-1:0];
         assign is_inject = (op == eicp_pkg::OP_INJECT_PHYS) || (op == eicp_pkg::OP_INJECT_LIN);
         assign in_range = (op == eicp_pkg::OP_INJECT_LIN) ? (adr <= LIN_MAX) : (adr <= PHYS_MAX);
         assign masked = eicp_pkg::MASK_EN && (adr >= eicp_pkg::MASK_LO) &&
                         (adr <= eicp_pkg::MASK_HI);

         always_comb begin
            r_d = r_q;
            r_d.fire = 1'b0;
            r_d.dropped = 1'b0;
            // A new strobe overwrites the pending word; the sender is trusted to space commands.
            if (strobe_in) begin
               r_d.cmd = word_in;
               r_d.pend = 1'b1;
            end else if (r_q.pend && r_q.state != eicp_pkg::ST_BOOT &&
                         r_q.state != eicp_pkg::ST_INIT && r_q.state != eicp_pkg::ST_INJECT) begin
               r_d.pend = 1'b0;
            end
            unique case (r_q.state)
               eicp_pkg::ST_BOOT: begin
                  r_d.state = eicp_pkg::ST_INIT;
                  r_d.cnt = eicp_pkg::CNT_RESET;
               end
               eicp_pkg::ST_INIT: begin
                  r_d.cnt = r_q.cnt + 4'h1;
                  if (r_q.cnt == eicp_pkg::INIT_CYCLES - 4'h1) begin
                     r_d.state = eicp_pkg::ST_OBSERVE;
                  end
               end
               eicp_pkg::ST_OBSERVE: begin
                  // Only go-idle is honoured here; anything else is silently dropped.
                  if (r_q.pend && op == eicp_pkg::OP_GO_IDLE) begin
                     r_d.state = eicp_pkg::ST_IDLE;
                  end
               end
               eicp_pkg::ST_IDLE: begin
                  if (r_q.pend) begin
                     if (op == eicp_pkg::OP_GO_OBSERVE) begin
                        r_d.state = eicp_pkg::ST_OBSERVE;
                     end else if (op == eicp_pkg::OP_SOFT_RESET) begin
                        r_d.state = eicp_pkg::ST_BOOT;
                     end else if (is_inject) begin
                        if (in_range && !masked) begin
                           r_d.state = eicp_pkg::ST_INJECT;
                           r_d.addr = adr;
                           r_d.linear = (op == eicp_pkg::OP_INJECT_LIN);
                        end else begin
                           r_d.dropped = 1'b1;
                        end
                     end
                  end
               end
               eicp_pkg::ST_INJECT: begin
                  r_d.fire = 1'b1;
                  r_d.state = eicp_pkg::ST_IDLE;
               end
               default: begin
                  r_d.state = eicp_pkg::ST_BOOT;
               end
            endcase
         end

         always_ff @(posedge clk_sys) begin
            if (srst) begin
               r_q <= '{state: eicp_pkg::ST_BOOT, cmd: '0, pend: 1'b0, cnt: eicp_pkg::CNT_RESET,
                        addr: '0, linear: 1'b0, fire: 1'b0, dropped: 1'b0};
            end else begin
               r_q <= r_d;
            end
         end

         assign status_initialization[g] = (r_q.state == eicp_pkg::ST_INIT);
         assign status_observation[g] = (r_q.state == eicp_pkg::ST_OBSERVE);
         assign status_idle[g] = (r_q.state == eicp_pkg::ST_IDLE);
         assign status_injection[g] = (r_q.state == eicp_pkg::ST_INJECT);
         assign inject_fire[g] = r_q.fire;
         assign inject_linear[g] = r_q.linear;
         assign inject_dropped[g] = r_q.dropped;
         assign inject_addr[g*eicp_pkg::ADDR_W +: eicp_pkg::ADDR_W] = r_q.addr;

         AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (srst)
            strobe_in |=> r_q.pend && r_q.cmd == $past(word_in))
            else $error("Strobed command word was not captured.");

         AST_PORT_OFF: assert property (@(posedge clk_sys) disable iff (srst)
            !PORT_EN |-> !r_q.pend)
            else $error("Disabled port delivered a command.");

         AST_OBS_IGNORE: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_OBSERVE && op != eicp_pkg::OP_GO_IDLE
            |=> r_q.state == eicp_pkg::ST_OBSERVE && !r_q.fire)
            else $error("Observation acted on a command other than go-idle.");

         AST_GO_IDLE: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.pend && !strobe_in && op == eicp_pkg::OP_GO_IDLE &&
            (r_q.state == eicp_pkg::ST_OBSERVE || r_q.state == eicp_pkg::ST_IDLE)
            |=> r_q.state == eicp_pkg::ST_IDLE)
            else $error("Go-idle did not reach idle.");

         AST_REBOOT: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_IDLE && r_q.pend && op == eicp_pkg::OP_SOFT_RESET
            |=> r_q.state == eicp_pkg::ST_BOOT ##1 r_q.state == eicp_pkg::ST_INIT)
            else $error("Soft reset did not reboot.");

         AST_INIT_LEN: assert property (@(posedge clk_sys) disable iff (srst)
            $rose(r_q.state == eicp_pkg::ST_INIT)
            |-> (r_q.state == eicp_pkg::ST_INIT)[*8] ##1 r_q.state == eicp_pkg::ST_OBSERVE)
            else $error("Initialization length wrong.");

         AST_DROP: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_IDLE && r_q.pend && is_inject && (!in_range || masked)
            |=> r_q.dropped && r_q.state == eicp_pkg::ST_IDLE ##1 !r_q.fire)
            else $error("Bad injection was not discarded.");

         AST_FIRE: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_IDLE && r_q.pend && is_inject && in_range && !masked
            |=> r_q.state == eicp_pkg::ST_INJECT && r_q.addr == $past(adr)
            ##1 r_q.fire && r_q.state == eicp_pkg::ST_IDLE)
            else $error("Valid injection did not fire.");

         AST_FIRE_PULSE: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.fire |=> !r_q.fire)
            else $error("Injection pulse lasted more than one cycle.");

         AST_FIRE_SRC: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.fire |-> $past(r_q.state == eicp_pkg::ST_INJECT))
            else $error("Injection fired outside the inject state.");

         AST_DROP_KEEP: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.dropped |-> r_q.addr == $past(r_q.addr) && r_q.linear == $past(r_q.linear))
            else $error("Discarded injection changed the target.");

         AST_INJECT_SRC: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_INJECT |-> $past(r_q.state) == eicp_pkg::ST_IDLE)
            else $error("Inject state entered from outside idle.");

         AST_BOOT_ENTRY: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_BOOT
            |=> r_q.state == eicp_pkg::ST_INIT && r_q.cnt == eicp_pkg::CNT_RESET)
            else $error("Boot did not restart initialization.");

         AST_IDLE_STAYS: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_IDLE && !r_q.pend |=> r_q.state == eicp_pkg::ST_IDLE)
            else $error("Idle was left without a command.");

         AST_OBS_STAYS: assert property (@(posedge clk_sys) disable iff (srst)
            r_q.state == eicp_pkg::ST_OBSERVE && !r_q.pend
            |=> r_q.state == eicp_pkg::ST_OBSERVE)
            else $error("Observation was left without a command.");

         if (g > 0) begin : g_same
            AST_SAME_CMD: assert property (@(posedge clk_sys) disable iff (srst)
               r_q.cmd == g_region[0].r_q.cmd && r_q.pend == g_region[0].r_q.pend)
               else $error("Regions saw different commands.");
         end
      end
   endgenerate

endmodule

/* File: tb/eicp_cmd_src.sv */
// Behavioural command source driving the port as an outside party would.
`timescale 1ns/1ps
module eicp_cmd_src (
   // Clock
   input wire logic clk_sys,
   // Command port
   output logic [eicp_pkg::CMD_W-1:0] cmd_word,
   output logic cmd_strobe
);
   initial begin
      cmd_word = 40'h00_0000_0000;
      cmd_strobe = 1'h0;
   end
   // The word is inverted after each strobe so a stale word never passes for a fresh one.
   task automatic send(input logic [3:0] op, input logic [35:0] a);
      @(negedge clk_sys);
      cmd_word = {op, a};
      cmd_strobe = 1'h1;
      @(negedge clk_sys);
      cmd_strobe = 1'h0;
      cmd_word = ~cmd_word;
   endtask
endmodule

/* File: tb/tb_error_injection_command_port.sv */
// Self-checking bench for the command port with two die regions.
`timescale 1ns/1ps
module tb_error_injection_command_port;
   logic clk_sys = 1'h0;
   logic srst = 1'h1;
   logic [39:0] cmd_word;
   logic cmd_strobe;
   logic [1:0] st_init, st_obs, st_idle, st_inj, fire, lin, drop;
   logic [71:0] addr;
   logic off_obs;
   logic off_idle;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   eicp_cmd_src u_eicp_cmd_src (.clk_sys(clk_sys), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe));
   eicp_port #(.NUM_REGIONS(2)) u_eicp_port (.clk_sys(clk_sys), .srst(srst),
      .cmd_word(cmd_word), .cmd_strobe(cmd_strobe), .status_initialization(st_init),
      .status_observation(st_obs), .status_idle(st_idle), .status_injection(st_inj),
      .inject_fire(fire), .inject_linear(lin), .inject_dropped(drop), .inject_addr(addr));
   // A second port built with the pins absent; it must never react to the shared strobe.
   eicp_port #(.NUM_REGIONS(1), .PORT_EN(1'b0)) u_eicp_port_off (.clk_sys(clk_sys),
      .srst(srst), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe), .status_initialization(),
      .status_observation(off_obs), .status_idle(off_idle), .status_injection(),
      .inject_fire(), .inject_linear(), .inject_dropped(), .inject_addr());
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic go(input logic [3:0] op, input logic [35:0] a, input int n);
      u_eicp_cmd_src.send(op, a);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // Counts initialization cycles after reset or reboot; no command is given meanwhile.
   task automatic t_boot();
      int k;
      k = 0;
      repeat (20) begin
         @(negedge clk_sys);
         if (st_init === 2'h3) k++;
      end
      chk("init_cycles", 72'(eicp_pkg::INIT_CYCLES), 72'(k));
      chk("observe", 72'h3, 72'(st_obs));
   endtask
   task automatic t_ignore();
      go(4'hc, 36'h0_0000_0005, 3);
      chk("fire_in_observe", 72'h0, 72'(fire));
      chk("still_observe", 72'h3, 72'(st_obs));
   endtask
   task automatic t_idle();
      go(4'he, 36'h0_0000_0000, 2);
      chk("idle", 72'h3, 72'(st_idle));
      chk("off_port", 72'h1, 72'({off_idle, off_obs}));
   endtask
   task automatic t_inject(input logic [3:0] op, input logic [35:0] a, input logic l);
      go(op, a, 1);
      chk("inject_state", 72'h3, 72'(st_inj));
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("fire", 72'h3, 72'(fire));
      chk("addr", {a, a}, addr);
      chk("linear", 72'({l, l}), 72'(lin));
   endtask
   task automatic t_drop();
      go(4'hd, eicp_pkg::LIN_ADDR_MAX + 36'h1, 1);
      chk("dropped", 72'h3, 72'(drop));
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("fire_after_drop", 72'h0, 72'(fire));
   endtask
   task automatic t_reboot();
      go(4'ha, 36'h0_0000_0000, 2);
      chk("to_observe", 72'h3, 72'(st_obs));
      t_idle();
      go(4'hb, 36'h0_0000_0000, 1);
      chk("boot", 72'h0, 72'({st_init, st_obs, st_idle, st_inj}));
      t_boot();
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 1000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      repeat (12) @(negedge clk_sys);
      srst = 1'h0;
      t_boot();
      t_ignore();
      t_idle();
      t_inject(4'hc, eicp_pkg::PHYS_ADDR_MAX, 1'h0);
      t_inject(4'hd, eicp_pkg::LIN_ADDR_MAX, 1'h1);
      t_drop();
      t_reboot();
      print_verdict();
   end
endmodule
